/* File: rtl/ssi_regs.vh */
`ifndef SSI_REGS_VH
`define SSI_REGS_VH
// Clock and cue times
`define SSI_CLK_KHZ 125000
`define SSI_BEEP_MS 80
`define SSI_GAP_MS 60
`define SSI_RAZZ_MS 400
`define SSI_PAUSE_MS 300
`define SSI_FLASH_MS 100
`define SSI_SLEEP_MS 15000
`define SSI_BEEP_CYC (`SSI_BEEP_MS * `SSI_CLK_KHZ)
`define SSI_GAP_CYC (`SSI_GAP_MS * `SSI_CLK_KHZ)
`define SSI_RAZZ_CYC (`SSI_RAZZ_MS * `SSI_CLK_KHZ)
`define SSI_PAUSE_CYC (`SSI_PAUSE_MS * `SSI_CLK_KHZ)
`define SSI_FLASH_CYC (`SSI_FLASH_MS * `SSI_CLK_KHZ)
`define SSI_SLEEP_CYC (`SSI_SLEEP_MS * `SSI_CLK_KHZ)
// Tone half periods in cycles
`define SSI_HP_T0 16'h5a6c
`define SSI_HP_T1 16'h4e20
`define SSI_HP_T2 16'h445c
`define SSI_HP_T3 16'h3d09
`define SSI_HP_T4 16'h3415
`define SSI_HP_T5 16'h2d36
`define SSI_HP_T6 16'h2710
`define SSI_HP_HIGH 16'h1e85
`define SSI_HP_LOW 16'h7a12
`define SSI_HP_RAZZ 16'hf424
// Register map
`define SSI_ADR_CTRL 2'h0
`define SSI_ADR_STAT 2'h1
`define SSI_CTRL_BEEP 0
`define SSI_CTRL_TONE 3:1
`define SSI_CTRL_VOL 5:4
`define SSI_CTRL_TMO 6
`define SSI_CTRL_RST 7'h24
`define SSI_TONE_OFF 3'h7
`define SSI_VOL_MAX 2'h2
`endif

/* File: rtl/ssi_status_ind.v */
// Functional notes
// - Power-up: amber on, red flash, beep, ready
// - Power-up red lit exactly during beep
// - Good read: red flash, optional beep
// - Eight tone settings, three volume levels
// - Program entry: red flash, three beeps
// - Program mode: red and amber flashing
// - Program exit: three beeps, red stops
// - Optional three beeps on comm timeout
// - Config done: three beeps, pause, high, low
// - Amber lit while laser active
// - Blink power save keeps amber lit
// - Red held while data awaits host
// - Invalid code in program mode: razz
// - Sleep: each LED flashes per 15 s
// - Host wait: red steady, amber off
// - Laser failure: amber flash, one razz
// - Motor failure: both flash, two razz
// - Config store failure: three power-up beeps
// - Electronic failure: continuous razz, LEDs off
`timescale 1ns/1ps
`include "ssi_regs.vh"
module ssi_status_ind #(
  parameter [31:0] BEEP_CYC  = `SSI_BEEP_CYC,
  parameter [31:0] GAP_CYC   = `SSI_GAP_CYC,
  parameter [31:0] RAZZ_CYC  = `SSI_RAZZ_CYC,
  parameter [31:0] PAUSE_CYC = `SSI_PAUSE_CYC,
  parameter [31:0] FLASH_CYC = `SSI_FLASH_CYC,
  parameter [31:0] SLEEP_CYC = `SSI_SLEEP_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Scanner events and states
  input  wire        good_read_i,
  input  wire        prog_i,
  input  wire        bad_code_i,
  input  wire        cfg_ok_i,
  input  wire        comm_tmo_i,
  input  wire        laser_on_i,
  input  wire        blink_save_i,
  input  wire        sleep_i,
  input  wire        host_wait_i,
  input  wire        data_pend_i,
  input  wire        laser_fail_i,
  input  wire        motor_fail_i,
  input  wire        nv_fail_i,
  input  wire        elec_fail_i,
  // Indicators
  output reg         red_led_o,
  output reg         amber_led_o,
  output reg         beep_o,
  output reg  [1:0]  vol_o,
  output reg         ready_o
);

  localparam S_IDLE = 3'b001;
  localparam S_ON   = 3'b010;
  localparam S_OFF  = 3'b100;
  localparam K_TONE = 2'h0;
  localparam K_RAZZ = 2'h1;
  localparam K_HIGH = 2'h2;
  localparam K_LOW  = 2'h3;
  // Request slots, lowest index wins
  localparam P_ELEC = 0;
  localparam P_MOT  = 1;
  localparam P_LAS  = 2;
  localparam P_NV   = 3;
  localparam P_BAD  = 4;
  localparam P_PROG = 5;
  localparam P_CFG  = 6;
  localparam P_TMO  = 7;
  localparam P_PWR  = 8;
  localparam P_GOOD = 9;

  // Pattern: {continuous, tail, kind, count}
  function [6:0] pat;
    input [3:0] idx;
    begin
      case (idx)
        P_ELEC:  pat = {1'b1, 1'b0, K_RAZZ, 3'h1};
        P_MOT:   pat = {1'b0, 1'b0, K_RAZZ, 3'h2};
        P_LAS:   pat = {1'b0, 1'b0, K_RAZZ, 3'h1};
        P_NV:    pat = {1'b0, 1'b0, K_TONE, 3'h3};
        P_BAD:   pat = {1'b0, 1'b0, K_RAZZ, 3'h1};
        P_PROG:  pat = {1'b0, 1'b0, K_TONE, 3'h3};
        P_CFG:   pat = {1'b0, 1'b1, K_TONE, 3'h3};
        P_TMO:   pat = {1'b0, 1'b0, K_TONE, 3'h3};
        default: pat = {1'b0, 1'b0, K_TONE, 3'h1};
      endcase
    end
  endfunction

  function [15:0] half_per;
    input [1:0] kind;
    input [2:0] tone;
    begin
      case ({kind, tone})
        5'h00:   half_per = `SSI_HP_T0;
        5'h01:   half_per = `SSI_HP_T1;
        5'h02:   half_per = `SSI_HP_T2;
        5'h03:   half_per = `SSI_HP_T3;
        5'h04:   half_per = `SSI_HP_T4;
        5'h05:   half_per = `SSI_HP_T5;
        5'h06:   half_per = `SSI_HP_T6;
        default:
        begin
          if (kind == K_HIGH)
            half_per = `SSI_HP_HIGH;
          else if (kind == K_LOW)
            half_per = `SSI_HP_LOW;
          else
            half_per = `SSI_HP_RAZZ;
        end
      endcase
    end
  endfunction

  reg  [6:0]  ctrl_r;
  reg  [9:0]  pend_r;
  reg  [9:0]  pend_nxt;
  reg  [2:0]  st_r;
  reg  [2:0]  left_r;
  reg  [1:0]  kind_r;
  reg         tail_r;
  reg         cont_r;
  reg  [31:0] tmr_r;
  reg  [15:0] tcnt_r;
  reg         init_r;
  reg         pu_r;
  reg         prog_r;
  reg         lf_r;
  reg         mf_r;
  reg         ef_r;
  reg  [31:0] fl_cnt_r;
  reg         fl_ph_r;
  reg  [31:0] gr_tmr_r;
  reg  [31:0] slp_r;
  reg  [3:0]  idx;
  reg         red_nxt;
  reg         amb_nxt;
  integer     i;

  wire        snd_on  = st_r[1];
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        fail    = lf_r | mf_r | ef_r;
  wire        normal  = ~pu_r & ~fail & ~prog_r;
  wire [6:0]  pick    = pat(idx);
  wire [31:0] on_len  = (pick[4:3] == K_RAZZ) ? RAZZ_CYC : BEEP_CYC;
  wire        mute    = (kind_r == K_TONE) & (ctrl_r[`SSI_CTRL_TONE] == `SSI_TONE_OFF);
  wire        gr_ev   = good_read_i & normal;
  wire        sleep_fl = sleep_i & (slp_r < FLASH_CYC);

  // Highest priority pending request
  always @*
  begin
    idx = 4'h0;
    for (i = 9; i >= 0; i = i - 1)
      if (pend_r[i])
        idx = i[3:0];
  end

  // Request collection; a new event wins over its own clear
  always @*
  begin
    pend_nxt = pend_r;
    if (st_r[0] && pend_r != 10'h000)
      pend_nxt[idx] = 1'b0;
    if (init_r)
    begin
      if (nv_fail_i)
        pend_nxt[P_NV] = 1'b1;
      else
        pend_nxt[P_PWR] = 1'b1;
    end
    if (elec_fail_i && !ef_r)
      pend_nxt[P_ELEC] = 1'b1;
    if (motor_fail_i && !mf_r)
      pend_nxt[P_MOT] = 1'b1;
    if (laser_fail_i && !lf_r)
      pend_nxt[P_LAS] = 1'b1;
    if (bad_code_i && prog_r)
      pend_nxt[P_BAD] = 1'b1;
    if (prog_i != prog_r && !pu_r)
      pend_nxt[P_PROG] = 1'b1;
    if (cfg_ok_i)
      pend_nxt[P_CFG] = 1'b1;
    if (comm_tmo_i && ctrl_r[`SSI_CTRL_TMO] && normal)
      pend_nxt[P_TMO] = 1'b1;
    if (gr_ev && ctrl_r[`SSI_CTRL_BEEP])
      pend_nxt[P_GOOD] = 1'b1;
    if (ef_r)
      pend_nxt = pend_nxt & 10'h001;
  end

  // Sound sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r   <= S_IDLE;
      left_r <= 3'h0;
      kind_r <= K_TONE;
      tail_r <= 1'b0;
      cont_r <= 1'b0;
      tmr_r  <= 32'h0;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          if (pend_r != 10'h000)
          begin
            st_r   <= S_ON;
            cont_r <= pick[6];
            tail_r <= pick[5];
            kind_r <= pick[4:3];
            left_r <= pick[2:0];
            tmr_r  <= on_len - 32'h1;
          end
        end
        S_ON:
        begin
          if (tmr_r != 32'h0)
            tmr_r <= tmr_r - 32'h1;
          else if (!cont_r)
          begin
            st_r  <= S_OFF;
            tmr_r <= GAP_CYC - 32'h1;
            if (left_r != 3'h0)
              left_r <= left_r - 3'h1;
            if (kind_r == K_HIGH)
              kind_r <= K_LOW;
          end
        end
        S_OFF:
        begin
          if (tmr_r != 32'h0)
            tmr_r <= tmr_r - 32'h1;
          else if (left_r != 3'h0)
          begin
            st_r  <= S_ON;
            tmr_r <= ((kind_r == K_RAZZ) ? RAZZ_CYC : BEEP_CYC) - 32'h1;
          end
          else if (tail_r)
          begin
            // Pause, then high and low tones
            tail_r <= 1'b0;
            kind_r <= K_HIGH;
            left_r <= 3'h2;
            tmr_r  <= PAUSE_CYC - 32'h1;
          end
          else
            st_r <= S_IDLE;
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // Tone generator
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tcnt_r <= 16'h0;
      beep_o <= 1'b0;
    end
    else if (!snd_on || mute)
    begin
      tcnt_r <= 16'h0;
      beep_o <= 1'b0;
    end
    else if (tcnt_r >= half_per(kind_r, ctrl_r[`SSI_CTRL_TONE]) - 16'h1)
    begin
      tcnt_r <= 16'h0;
      beep_o <= ~beep_o;
    end
    else
      tcnt_r <= tcnt_r + 16'h1;
  end

  // Status tracking and timers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_r   <= 10'h000;
      init_r   <= 1'b1;
      pu_r     <= 1'b1;
      prog_r   <= 1'b0;
      lf_r     <= 1'b0;
      mf_r     <= 1'b0;
      ef_r     <= 1'b0;
      fl_cnt_r <= 32'h0;
      fl_ph_r  <= 1'b0;
      gr_tmr_r <= 32'h0;
      slp_r    <= 32'h0;
      ready_o  <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      init_r <= 1'b0;
      if (!init_r && st_r[0] && !pend_r[P_PWR] && !pend_r[P_NV])
        pu_r <= 1'b0;
      ready_o <= ~pu_r & ~fail;
      if (!pu_r)
        prog_r <= prog_i;
      lf_r <= lf_r | laser_fail_i;
      mf_r <= mf_r | motor_fail_i;
      ef_r <= ef_r | elec_fail_i;
      if (fl_cnt_r >= FLASH_CYC - 32'h1)
      begin
        fl_cnt_r <= 32'h0;
        fl_ph_r  <= ~fl_ph_r;
      end
      else
        fl_cnt_r <= fl_cnt_r + 32'h1;
      if (gr_ev)
        gr_tmr_r <= FLASH_CYC;
      else if (gr_tmr_r != 32'h0)
        gr_tmr_r <= gr_tmr_r - 32'h1;
      if (!sleep_i || slp_r >= SLEEP_CYC - 32'h1)
        slp_r <= 32'h0;
      else
        slp_r <= slp_r + 32'h1;
    end
  end

  // Indicator selection by priority
  always @*
  begin
    red_nxt = 1'b0;
    amb_nxt = 1'b0;
    if (ef_r)
    begin
      red_nxt = 1'b0;
      amb_nxt = 1'b0;
    end
    else if (mf_r)
    begin
      red_nxt = fl_ph_r;
      amb_nxt = fl_ph_r;
    end
    else if (lf_r)
      amb_nxt = fl_ph_r;
    else if (pu_r)
    begin
      amb_nxt = 1'b1;
      red_nxt = snd_on;
    end
    else if (prog_r)
    begin
      red_nxt = fl_ph_r;
      amb_nxt = ~fl_ph_r;
    end
    else if (sleep_i)
    begin
      red_nxt = sleep_fl;
      amb_nxt = sleep_fl;
    end
    else if (host_wait_i)
      red_nxt = 1'b1;
    else
    begin
      amb_nxt = laser_on_i | blink_save_i;
      red_nxt = (gr_tmr_r != 32'h0) | data_pend_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      red_led_o   <= 1'b0;
      amber_led_o <= 1'b0;
      vol_o       <= `SSI_VOL_MAX;
    end
    else
    begin
      red_led_o   <= red_nxt;
      amber_led_o <= amb_nxt;
      vol_o       <= ctrl_r[`SSI_CTRL_VOL];
    end
  end

  // Wishbone register slave
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r   <= `SSI_CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i && wb_adr_i[3:2] == `SSI_ADR_CTRL)
        wb_dat_o <= {25'h0, ctrl_r};
      if (wb_req && !wb_we_i && wb_adr_i[3:2] == `SSI_ADR_STAT)
        wb_dat_o <= {24'h0, snd_on, st_r[0], pend_r != 10'h000, fail,
                     amber_led_o, red_led_o, prog_r, ready_o};
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == `SSI_ADR_CTRL)
      begin
        ctrl_r[`SSI_CTRL_BEEP] <= wb_dat_i[0];
        ctrl_r[`SSI_CTRL_TONE] <= wb_dat_i[3:1];
        ctrl_r[`SSI_CTRL_TMO]  <= wb_dat_i[6];
        if (wb_dat_i[5:4] > `SSI_VOL_MAX)
          ctrl_r[`SSI_CTRL_VOL] <= `SSI_VOL_MAX;
        else
          ctrl_r[`SSI_CTRL_VOL] <= wb_dat_i[5:4];
      end
    end
  end

endmodule // ssi_status_ind

/* File: test/ssi_ind_model.sv */
`timescale 1ns/1ps
module ssi_ind_model (
  // Clock
  input  logic clk_i,
  // Lamps
  input  logic red_i,
  input  logic amb_i,
  // Lamp counts
  output int   red_n_o,
  output int   amb_n_o,
  output int   len_o,
  output int   gap_o
);
  logic red_r = 1'h0;
  logic amb_r = 1'h0;
  int   t     = 0;
  int   t_r   = 0;
  always @(posedge clk_i)
  begin
    t <= t + 1;
    red_r <= red_i === 1'h1;
    amb_r <= amb_i === 1'h1;
    if (amb_i === 1'h1 && !amb_r)
      amb_n_o <= amb_n_o + 1;
    // Red rise: period since last rise
    if (red_i === 1'h1 && !red_r)
    begin
      red_n_o <= red_n_o + 1;
      gap_o <= t - t_r;
      t_r <= t;
    end
    if (red_i !== 1'h1 && red_r)
      len_o <= t - t_r;
  end
endmodule // ssi_ind_model

/* File: test/ssi_status_ind_chk.sv */
`timescale 1ns/1ps
module ssi_status_ind_chk (
  // Clock and reset
  input logic       clk_i,
  input logic       rst_i,
  // Scanner events and states
  input logic       good_read_i,
  input logic       prog_i,
  input logic       laser_on_i,
  input logic       blink_save_i,
  input logic       sleep_i,
  input logic       host_wait_i,
  input logic       data_pend_i,
  input logic       laser_fail_i,
  input logic       motor_fail_i,
  input logic       elec_fail_i,
  // Indicators
  input logic       red_led_o,
  input logic       amber_led_o,
  input logic [1:0] vol_o,
  input logic       ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire quiet = ready_o && !prog_i && !sleep_i;
  elec_dark_a: assert property ($past(elec_fail_i, 2) |-> !red_led_o && !amber_led_o)
    else $error("leds lit");
  fail_ready_a: assert property (
    $rose(laser_fail_i || motor_fail_i || elec_fail_i) |-> ##[1:3] !ready_o)
    else $error("ready kept");
  vol_range_a: assert property (vol_o != 2'h3)
    else $error("bad volume");
  good_red_a: assert property (good_read_i && quiet |-> ##2 red_led_o [*8])
    else $error("no red flash");
  laser_amber_a: assert property (
    (quiet && !host_wait_i && (laser_on_i || blink_save_i)) [*3] |-> amber_led_o)
    else $error("amber off");
  pend_red_a: assert property ((quiet && data_pend_i) [*3] |-> red_led_o)
    else $error("red off");
  host_wait_a: assert property (
    (quiet && host_wait_i && !laser_on_i && !blink_save_i) [*3]
    |-> red_led_o && !amber_led_o)
    else $error("host wait leds");
  sleep_pair_a: assert property (
    (ready_o && sleep_i && !prog_i) [*3] |-> red_led_o == amber_led_o)
    else $error("sleep leds");
endmodule // ssi_status_ind_chk
bind ssi_status_ind ssi_status_ind_chk i_ssi_status_ind_chk (.*);

/* File: test/ssi_status_ind_tb.sv */
`timescale 1ns/1ps
`include "ssi_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module ssi_status_ind_tb;
  localparam int B = 20;
  localparam int F = 8;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          k, n0, n1, red_n, amb_n, len, gap;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc   = 1'h0;
  logic        we    = 1'h0;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [31:0] rnd   = 32'h03d1;
  logic [31:0] rd;
  // Event bits in port order, good read at 0 to elec failure at 13
  logic [13:0] ev    = 14'h0;
  wire  [31:0] rdat;
  wire  [1:0]  vol;
  wire         ack, red, amb, bp, rdy;
  ssi_status_ind #(.BEEP_CYC(B), .GAP_CYC(10), .RAZZ_CYC(40), .PAUSE_CYC(30),
    .FLASH_CYC(F), .SLEEP_CYC(200)) i_ssi_status_ind (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .good_read_i(ev[0]), .prog_i(ev[1]), .bad_code_i(ev[2]), .cfg_ok_i(ev[3]),
    .comm_tmo_i(ev[4]), .laser_on_i(ev[5]), .blink_save_i(ev[6]), .sleep_i(ev[7]),
    .host_wait_i(ev[8]), .data_pend_i(ev[9]), .laser_fail_i(ev[10]),
    .motor_fail_i(ev[11]), .nv_fail_i(ev[12]), .elec_fail_i(ev[13]),
    .red_led_o(red), .amber_led_o(amb), .beep_o(bp), .vol_o(vol), .ready_o(rdy));
  ssi_ind_model i_ssi_ind_model (.clk_i(clk_i), .red_i(red), .amb_i(amb),
    .red_n_o(red_n), .amb_n_o(amb_n), .len_o(len), .gap_o(gap));
  initial
    forever #4 clk_i = ~clk_i;
  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rd = rdat;
    cyc <= 1'h0;
    if (ack !== 1'h1)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  // Count tone starts seen in the status word
  task automatic tones(input int c, output int t);
    logic p;
    p = 1'h0;
    t = 0;
    repeat (c / 3)
    begin
      wb(1'h0, 4'h4, 32'h0);
      if (rd[7] === 1'h1 && !p)
        t++;
      p = rd[7] === 1'h1;
    end
  endtask
  task automatic lvl(input int i, input logic v);
    @(posedge clk_i);
    ev[i] <= v;
  endtask
  task automatic pulse(input int i);
    lvl(i, 1'h1);
    lvl(i, 1'h0);
  endtask
  task automatic boot(input logic nvf);
    @(posedge clk_i);
    rst_i <= 1'h1;
    ev <= {1'h0, nvf, 12'h0};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask
  initial
  begin
    boot(1'h0);
    tones(90, k);
    `CHK(k, 1)
    `CHK(red_n, 1)
    `CHK(len, B)
    `CHK(amb_n, 1)
    `CHK(rdy, 1'h1)
    wb(1'h0, 4'h0, 32'h0);
    `CHK(rd, 32'h24)
    wb(1'h0, 4'h8, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 8; i++)
    begin
      k = xs() & 3;
      n0 = k > 2 ? 2 : k;
      wb(1'h1, 4'h0, {26'h0, k[1:0], i[2:0], 1'h1});
      wb(1'h0, 4'h0, 32'h0);
      `CHK(rd[5:0], {n0[1:0], i[2:0], 1'h1})
      `CHK(vol, n0[1:0])
    end
    wb(1'h1, 4'h0, 32'h21);
    n0 = red_n;
    pulse(0);
    tones(45, k);
    `CHK(k, 1)
    `CHK(len, F)
    wb(1'h1, 4'h0, 32'h20);
    pulse(0);
    tones(45, k);
    `CHK(k, 0)
    `CHK(red_n - n0, 2)
    for (int j = 0; j < 2; j++)
    begin
      wb(1'h1, 4'h0, 32'h20 | (j << 6));
      pulse(4);
      tones(120, k);
      `CHK(k, 3 * j)
    end
    pulse(3);
    tones(240, k);
    `CHK(k, 5)
    lvl(1, 1'h1);
    tones(120, k);
    `CHK(k, 3)
    n0 = amb_n;
    n1 = red_n;
    pulse(0);
    tones(60, k);
    `CHK(k, 0)
    `CHK(amb_n - n0 > 2 && red_n - n1 > 2, 1'h1)
    pulse(2);
    tones(75, k);
    `CHK(k, 1)
    lvl(1, 1'h0);
    tones(120, k);
    `CHK(k, 3)
    n1 = red_n;
    repeat (40) @(posedge clk_i);
    `CHK(red_n, n1)
    lvl(5, 1'h1);
    repeat (5) @(posedge clk_i);
    `CHK(amb, 1'h1)
    lvl(5, 1'h0);
    repeat (3) @(posedge clk_i);
    `CHK(amb, 1'h0)
    lvl(6, 1'h1);
    repeat (3) @(posedge clk_i);
    repeat (30)
    begin
      rd = xs();
      lvl(5, rd[0]);
      `CHK(amb, 1'h1)
    end
    @(posedge clk_i);
    ev[6:5] <= 2'h0;
    lvl(9, 1'h1);
    repeat (4) @(posedge clk_i);
    `CHK(red, 1'h1)
    lvl(9, 1'h0);
    lvl(8, 1'h1);
    repeat (4) @(posedge clk_i);
    `CHK({red, amb}, 2'h2)
    lvl(8, 1'h0);
    lvl(7, 1'h1);
    repeat (450) @(posedge clk_i);
    `CHK(gap, 200)
    `CHK(len, F)
    lvl(7, 1'h0);
    for (int f = 10; f < 12; f++)
    begin
      boot(1'h0);
      tones(90, k);
      lvl(1, f == 10);
      tones(120, k);
      lvl(f, 1'h1);
      repeat (3) @(posedge clk_i);
      n0 = amb_n;
      n1 = red_n;
      tones(120, k);
      `CHK(k, f - 9)
      `CHK(rdy, 1'h0)
      `CHK(amb_n - n0 > 1 && (red_n - n1 > 1) == (f == 11), 1'h1)
    end
    boot(1'h1);
    tones(120, k);
    `CHK(k, 3)
    boot(1'h0);
    tones(90, k);
    lvl(13, 1'h1);
    tones(150, k);
    `CHK({k[1:0], rd[7], red, amb}, 5'h0c)
    // Razz square wave must toggle after one half period
    n0 = 0;
    while (bp !== 1'h1 && n0 < 70000)
    begin
      @(posedge clk_i);
      n0++;
    end
    `CHK(bp, 1'h1)
    `CHK(n0 > `SSI_HP_RAZZ - 200 && n0 < `SSI_HP_RAZZ, 1'h1)
    tally_and_finish();
  end
endmodule // ssi_status_ind_tb
